// ### verilog/dac_port_consts.vh
// Purpose: Constants for the quad converter serial write port
// Assumes: Included by the port design files only
// Notes:   Field positions refer to the 24-bit received word
`ifndef DAC_PORT_CONSTS_VH
`define DAC_PORT_CONSTS_VH

`define FRAME_BITS      24
`define CNT_W           5
`define CNT_FULL        5'h18
`define DATA_W          16
`define ADDR_HI_POS     23
`define ADDR_LO_POS     22
`define LDSEL1_POS      21
`define LDSEL0_POS      20
`define CHSEL_HI_POS    18
`define CHSEL_LO_POS    17
`define PDSEL_POS       16
`define DATA_RESET      16'h0000
`define CMD_STORE       2'h0
`define CMD_UPDATE      2'h1
`define CMD_SIMUL       2'h2
`define CMD_BCAST       2'h3
`define FRAME_GAP_NS    130
`define CLK_PERIOD_NS   100
`define FRAME_GAP_CYC   ((`FRAME_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### verilog/chan_regs.v
// Purpose: Buffer and output register pair of one converter channel
// Assumes: Strobes are single-cycle pulses on REF_CLK
// Notes:   Output register loads from buffer or from fresh data
`timescale 1ns/1ns
`default_nettype none
`include "dac_port_consts.vh"
module chan_regs (
    input  wire                 clk,        // Core clock
    input  wire                 rst,        // Synchronous reset
    input  wire                 buf_we,     // Store fresh data into buffer
    input  wire                 out_we_new, // Load output from fresh data
    input  wire                 out_we_buf, // Load output from buffer
    input  wire [`DATA_W-1:0]   din,        // Fresh data
    output reg  [`DATA_W-1:0]   buf_q,      // Buffer contents
    output reg  [`DATA_W-1:0]   out_q       // Output register contents
);
    // ==================================================
    // Buffer and output registers
    always @(posedge clk) begin
        if (rst) begin
            buf_q <= `DATA_RESET;
            out_q <= `DATA_RESET;
        end else begin
            if (buf_we) begin
                buf_q <= din;
            end
            if (out_we_new) begin
                out_q <= din;
            end else if (out_we_buf) begin
                out_q <= buf_q; // RULE_13
            end
        end
    end
endmodule
`default_nettype wire

// ### verilog/dac_serial_port.v
// Behaviour
// RULE_01 - Low frame sync enables shifting; data sampled on falling serial clock
// RULE_02 - One bit per falling edge into a 24-bit shift register
// RULE_03 - Act on frame once 24th falling edge is received
// RULE_04 - Sync rising before 24th edge aborts frame with no update
// RULE_05 - Device address comes from two static address pins
// RULE_06 - Serial logic connected only while port enable is low
// RULE_07 - Load-all rising edge loads every output register together
// RULE_08 - Host waits 130 ns after 24th edge before next sync fall
// RULE_09 - Shift register locks after 24th edge within the frame
// RULE_10 - Top 8 bits control, low 16 bits data
// RULE_11 - Bits 23/22 must match address pins unless broadcast
// RULE_12 - Frame starts at sync falling edge; bit count restarts
// RULE_13 - Load-all copies each buffer register into its output
//
// Purpose: Serial write port of a quad 16-bit converter
// Assumes: All pins but RST asynchronous to REF_CLK; serial clock far slower
// Notes:   Power-down select bit is kept but drives nothing here
`timescale 1ns/1ns
`default_nettype none
`include "dac_port_consts.vh"
module dac_serial_port (
    input  wire                 REF_CLK,      // 10 MHz core clock
    input  wire                 RST,          // Synchronous reset, high
    input  wire                 SYNC_N,       // Frame sync, active low
    input  wire                 SCLK,         // Serial clock pin
    input  wire                 SDIN,         // Serial data pin
    input  wire                 ENABLE_N,     // Port enable, active low
    input  wire                 ADDR_SELECT_BIT0, // Address pin, low bit
    input  wire                 ADDR_SELECT_BIT1, // Address pin, high bit
    input  wire                 LOAD_ALL_OUTPUTS, // Load-all pin, rising edge
    output reg  [`DATA_W-1:0]   OUT_A,        // Channel A output register
    output reg  [`DATA_W-1:0]   OUT_B,        // Channel B output register
    output reg  [`DATA_W-1:0]   OUT_C,        // Channel C output register
    output reg  [`DATA_W-1:0]   OUT_D,        // Channel D output register
    output reg                  FRAME_DONE,   // Pulse: 24-bit frame received, any address
    output reg                  FRAME_ABORT   // Pulse: frame aborted
);
    // ==================================================
    // Input synchronisers
    // Bit order: 6 load, 5 high address, 4 low address, 3 enable,
    // 2 data, 1 serial clock, 0 frame sync
    reg  [6:0] meta_reg;
    reg  [6:0] sync_reg;
    reg        sclk_d_reg;
    reg        syncn_d_reg;
    reg        ld_d_reg;
    // Gated pin views; a disabled port looks idle to the frame logic
    wire       en_s    = ~sync_reg[3];
    wire       sclk_s  = sync_reg[1] | ~en_s;          // RULE_06
    wire       syncn_s = sync_reg[0] | ~en_s;          // RULE_06
    wire       sdin_s  = sync_reg[2];
    wire [1:0] addr_s  = {sync_reg[5], sync_reg[4]};   // RULE_05
    // Two stages per pin, then a delayed copy for edge detection
    always @(posedge REF_CLK) begin
        if (RST) begin
            meta_reg    <= 7'h4F;
            sync_reg    <= 7'h4F;
            sclk_d_reg  <= 1'b1;
            syncn_d_reg <= 1'b1;
            ld_d_reg    <= 1'b1;
        end else begin
            meta_reg    <= {LOAD_ALL_OUTPUTS, ADDR_SELECT_BIT1, ADDR_SELECT_BIT0,
                            ENABLE_N, SDIN, SCLK, SYNC_N};
            sync_reg    <= meta_reg;
            sclk_d_reg  <= sclk_s;
            syncn_d_reg <= syncn_s;
            ld_d_reg    <= sync_reg[6];
        end
    end
    // Edge detectors; load idles high in reset so no false rise follows
    wire       sclk_fall  = sclk_d_reg & ~sclk_s;
    wire       sync_fall  = syncn_d_reg & ~syncn_s;
    wire       sync_rise  = ~syncn_d_reg & syncn_s;
    wire       ld_rise    = ~ld_d_reg & sync_reg[6];

    // ==================================================
    // Frame state machine
    localparam [2:0] S_IDLE  = 3'b001;
    localparam [2:0] S_SHIFT = 3'b010;
    localparam [2:0] S_LOCK  = 3'b100;
    reg [2:0]             state_reg;
    reg [2:0]             state_next;
    reg [`FRAME_BITS-1:0] shift_reg;
    reg [`FRAME_BITS-1:0] shift_next;
    reg [`CNT_W-1:0]      cnt_reg;
    reg [`CNT_W-1:0]      cnt_next;
    reg                   exec_next;
    reg                   abort_next;
    // Next-state and shift logic
    always @* begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        exec_next  = 1'b0;
        abort_next = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (sync_fall) begin
                    state_next = S_SHIFT;                // RULE_12
                    cnt_next   = {`CNT_W{1'b0}};         // RULE_12
                end
            end
            S_SHIFT: begin
                if (syncn_s) begin
                    state_next = S_IDLE;                 // RULE_04
                    shift_next = {`FRAME_BITS{1'b0}};    // RULE_04
                    abort_next = sync_rise;
                end else if (sclk_fall) begin
                    shift_next = {shift_reg[`FRAME_BITS-2:0], sdin_s}; // RULE_01 RULE_02
                    cnt_next   = cnt_reg + 1'b1;
                    if (cnt_reg == `CNT_FULL - 1'b1) begin
                        state_next = S_LOCK;             // RULE_09
                        exec_next  = 1'b1;               // RULE_03
                    end
                end
            end
            S_LOCK: begin
                if (sync_fall) begin
                    state_next = S_SHIFT;                // RULE_12
                    cnt_next   = {`CNT_W{1'b0}};
                end else if (syncn_s) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
    end
    // Frame registers
    reg exec_reg;
    always @(posedge REF_CLK) begin
        if (RST) begin
            state_reg <= S_IDLE;
            shift_reg <= {`FRAME_BITS{1'b0}};
            cnt_reg   <= {`CNT_W{1'b0}};
            exec_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            exec_reg  <= exec_next;
        end
    end

    // ==================================================
    // Command decode
    wire [1:0]         cmd    = shift_reg[`LDSEL1_POS:`LDSEL0_POS];       // RULE_10
    wire [1:0]         chsel  = shift_reg[`CHSEL_HI_POS:`CHSEL_LO_POS];
    wire [`DATA_W-1:0] data   = shift_reg[`DATA_W-1:0];                   // RULE_10
    wire               bcast  = (cmd == `CMD_BCAST);
    wire               match  = (shift_reg[`ADDR_HI_POS] == addr_s[1]) &&
                                (shift_reg[`ADDR_LO_POS] == addr_s[0]);  // RULE_11
    wire               go     = exec_reg & (match | bcast);              // RULE_11
    reg  [3:0]         buf_we;
    reg  [3:0]         we_new;
    reg  [3:0]         we_buf;
    reg  [3:0]         sel;
    // Per-channel strobes
    always @* begin
        sel    = 4'h1 << chsel;
        buf_we = 4'h0;
        we_new = 4'h0;
        we_buf = 4'h0;
        if (go) begin
            if (cmd == `CMD_STORE) begin
                buf_we = sel;
            end else if (cmd == `CMD_UPDATE) begin
                buf_we = sel;
                we_new = sel;
            end else if (cmd == `CMD_SIMUL) begin
                buf_we = sel;
                we_new = sel;
                we_buf = ~sel;
            end else if (shift_reg[`CHSEL_HI_POS]) begin
                buf_we = 4'hF;
                we_new = 4'hF;
            end else begin
                we_buf = 4'hF;
            end
        end
        if (ld_rise) begin
            we_buf = 4'hF;                               // RULE_07
        end
    end

    // ==================================================
    // Channel register banks
    wire [`DATA_W*4-1:0] out_bus;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
            chan_regs u_ch (
                .clk        (REF_CLK),
                .rst        (RST),
                .buf_we     (buf_we[gi]),
                .out_we_new (we_new[gi]),
                .out_we_buf (we_buf[gi]),
                .din        (data),
                .buf_q      (),
                .out_q      (out_bus[gi*`DATA_W +: `DATA_W])
            );
        end
    endgenerate

    // ==================================================
    // Registered outputs
    always @(posedge REF_CLK) begin
        if (RST) begin
            OUT_A       <= `DATA_RESET;
            OUT_B       <= `DATA_RESET;
            OUT_C       <= `DATA_RESET;
            OUT_D       <= `DATA_RESET;
            FRAME_DONE  <= 1'b0;
            FRAME_ABORT <= 1'b0;
        end else begin
            OUT_A       <= out_bus[`DATA_W-1:0];
            OUT_B       <= out_bus[2*`DATA_W-1:`DATA_W];
            OUT_C       <= out_bus[3*`DATA_W-1:2*`DATA_W];
            OUT_D       <= out_bus[4*`DATA_W-1:3*`DATA_W];
            FRAME_DONE  <= exec_reg;
            FRAME_ABORT <= abort_next;
        end
    end
endmodule
`default_nettype wire

// ### bench/dac_serial_port_checker.sv
// Purpose: Port-level checks of the serial write port
// Assumes: Bound to every dac_serial_port
// Notes:   Outputs may move only after a frame or a load-pin rise
`timescale 1ns/1ns
`default_nettype none
module dac_serial_port_checker (
    input wire logic        REF_CLK,  // Clock
    input wire logic        RST,      // Reset
    input wire logic        SYNC_N,   // Sync
    input wire logic        SCLK,     // Serial clock
    input wire logic        SDIN,     // Data
    input wire logic        ENABLE_N, // Enable
    input wire logic        ADDR_SELECT_BIT0, // Address
    input wire logic        ADDR_SELECT_BIT1, // Address
    input wire logic        LOAD_ALL_OUTPUTS, // Load pin
    input wire logic [15:0] OUT_A,    // Channel A
    input wire logic [15:0] OUT_B,    // Channel B
    input wire logic [15:0] OUT_C,    // Channel C
    input wire logic [15:0] OUT_D,    // Channel D
    input wire logic        FRAME_DONE,  // Done pulse
    input wire logic        FRAME_ABORT  // Abort pulse
);
    // ==========
    // Age of the last load-pin rise
    logic       ld_d_reg;
    logic [3:0] ld_age_reg;
    wire  [63:0] outs = {OUT_A, OUT_B, OUT_C, OUT_D};
    always @(posedge REF_CLK) begin
        ld_d_reg <= LOAD_ALL_OUTPUTS;
        if (RST)
            ld_age_reg <= 4'hf;
        else if (LOAD_ALL_OUTPUTS && !ld_d_reg)
            ld_age_reg <= 4'h0;
        else if (ld_age_reg != 4'hf)
            ld_age_reg <= ld_age_reg + 4'h1;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    a_pulses_exclusive: assert property (!(FRAME_DONE && FRAME_ABORT))
        else $error("done and abort together");
    a_done_one_cycle: assert property (FRAME_DONE |=> !FRAME_DONE)
        else $error("done pulse too long");
    a_abort_one_cycle: assert property (FRAME_ABORT |=> !FRAME_ABORT)
        else $error("abort pulse too long");
    a_abort_after_rise: assert property (FRAME_ABORT |-> $past(SYNC_N | ENABLE_N, 2))
        else $error("abort without sync high");
    a_outs_hold: assert property ($changed(outs) |-> FRAME_DONE || $past(FRAME_DONE)
        || ld_age_reg < 4'ha) else $error("outputs moved without cause");
    a_disabled_quiet: assert property (ENABLE_N [*8] |=> !FRAME_DONE)
        else $error("frame done while disabled");
    a_sync_idle_quiet: assert property (SYNC_N [*8] |=> !FRAME_DONE)
        else $error("frame done while sync idle");
    a_reset_clears: assert property (disable iff (1'b0) RST |=> outs == 64'h0 && !FRAME_DONE
        && !FRAME_ABORT) else $error("reset did not clear");
    c_done: cover property (FRAME_DONE);
    c_abort: cover property (FRAME_ABORT);
    c_load: cover property (ld_age_reg == 4'h0);
endmodule
bind dac_serial_port dac_serial_port_checker chk (.REF_CLK(REF_CLK), .RST(RST),
    .SYNC_N(SYNC_N), .SCLK(SCLK), .SDIN(SDIN), .ENABLE_N(ENABLE_N),
    .ADDR_SELECT_BIT0(ADDR_SELECT_BIT0), .ADDR_SELECT_BIT1(ADDR_SELECT_BIT1),
    .LOAD_ALL_OUTPUTS(LOAD_ALL_OUTPUTS), .OUT_A(OUT_A), .OUT_B(OUT_B), .OUT_C(OUT_C),
    .OUT_D(OUT_D), .FRAME_DONE(FRAME_DONE), .FRAME_ABORT(FRAME_ABORT));
`default_nettype wire

// ### bench/host_serial_model.sv
// Purpose: Host end of the three-wire serial link
// Assumes: 800 ns serial clock, four core cycles per half
// Notes:   Data line shows the inverse of its last bit when idle
`timescale 1ns/1ns
`default_nettype none
module host_serial_model (
    input  wire logic REF_CLK, // Core clock
    output var  logic SYNC_N,  // Frame sync
    output var  logic SCLK,    // Serial clock, still between frames
    output var  logic SDIN     // Serial data
);
    // ==========
    // Idle levels
    initial begin
        SYNC_N = 1'b1;
        SCLK = 1'b0;
        SDIN = 1'b0;
    end
    // One frame, MSB first; fewer than 24 clocks aborts it
    task automatic send(input logic [23:0] w, input int nb);
        @(posedge REF_CLK);
        SYNC_N <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        for (int i = 0; i < nb; i++) begin
            SCLK <= 1'b1;
            SDIN <= (i < 24) ? w[23 - i] : 1'($urandom);
            repeat (4) @(posedge REF_CLK);
            SCLK <= 1'b0;
            repeat (4) @(posedge REF_CLK);
        end
        repeat (2) @(posedge REF_CLK);
        SYNC_N <= 1'b1;
        SDIN <= ~SDIN;
        repeat (20) @(posedge REF_CLK);
    endtask
endmodule
`default_nettype wire

// ### bench/tb_dac_serial_port.sv
// Purpose: Self-checking bench of the serial write port
// Assumes: Host model drives the link pins
// Notes:   Each frame result is checked two cycles after its pulse
`timescale 1ns/1ns
`default_nettype none
module tb_dac_serial_port;
    // ==========
    // Pins and reference channel state
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic enable_n = 1'b0;
    logic load_all = 1'b0;
    logic [1:0] ad;
    wire sync_n, sclk, sdin, done, abort;
    wire [15:0] out_a, out_b, out_c, out_d;
    logic [15:0] b [4] = '{4{16'h0}};
    logic [15:0] o [4] = '{4{16'h0}};
    logic [64:0] q [$];
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    host_serial_model host (.REF_CLK(ref_clk), .SYNC_N(sync_n), .SCLK(sclk), .SDIN(sdin));
    dac_serial_port DUT (.REF_CLK(ref_clk), .RST(rst), .SYNC_N(sync_n), .SCLK(sclk),
        .SDIN(sdin), .ENABLE_N(enable_n), .ADDR_SELECT_BIT0(ad[0]), .ADDR_SELECT_BIT1(ad[1]),
        .LOAD_ALL_OUTPUTS(load_all), .OUT_A(out_a), .OUT_B(out_b), .OUT_C(out_c),
        .OUT_D(out_d), .FRAME_DONE(done), .FRAME_ABORT(abort));
    initial forever #50 ref_clk = ~ref_clk;
    task stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task cmp(input logic [64:0] e, input logic [64:0] s, input string n);
        checked++;
        if (e !== s) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    function logic [23:0] mk(input logic [1:0] a, c, h, input logic [15:0] d);
        return {a, c, 1'b0, h, 1'b0, d};
    endfunction
    // Model one frame, note its outcome, then send it
    task frame(input logic [23:0] w, input int nb);
        if (nb >= 24 && w[21:20] == 2'h3) begin
            for (int i = 0; i < 4; i++) begin
                if (w[18]) b[i] = w[15:0];
                o[i] = b[i];
            end
        end else if (nb >= 24 && w[23:22] == ad) begin
            b[w[18:17]] = w[15:0];
            if (w[21:20] == 2'h1) o[w[18:17]] = w[15:0];
            if (w[21:20] == 2'h2) o = b;
        end
        q.push_back({nb < 24, o[0], o[1], o[2], o[3]});
        host.send(w, nb);
    endtask
    // Results watcher
    always @(posedge ref_clk) begin
        logic [64:0] e;
        logic k;
        if (done === 1'b1 || abort === 1'b1) begin
            k = abort;
            e = (q.size() > 0) ? q.pop_front() : 65'bx;
            repeat (2) @(posedge ref_clk);
            cmp(e, {k, out_a, out_b, out_c, out_d}, "outputs");
        end
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            fails++;
            stop_test;
        end
    end
    // ==========
    // Main sequence
    initial begin
        void'($urandom(32'h03f3));
        ad <= 2'($urandom);
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        for (int h = 0; h < 4; h++) frame(mk(ad, 2'h0, 2'(h), 16'($urandom)), 24);
        load_all <= 1'b1;
        repeat (6) @(posedge ref_clk);
        load_all <= 1'b0;
        repeat (6) @(posedge ref_clk);
        o = b;
        frame(mk(~ad, 2'h1, 2'h0, 16'($urandom)), 24);
        $display("store and load test done");
        for (int h = 0; h < 4; h++) frame(mk(ad, 2'h1, 2'(h), 16'($urandom)), 28);
        frame(mk(ad, 2'h0, 2'h0, 16'($urandom)), 24);
        frame(mk(ad, 2'h2, 2'h1, 16'($urandom)), 24);
        frame(mk(~ad, 2'h3, 2'h2, 16'($urandom)), 24);
        frame(mk(ad, 2'h0, 2'h3, 16'($urandom)), 24);
        frame(mk(~ad, 2'h3, 2'h0, 16'($urandom)), 24);
        $display("update and broadcast test done");
        frame(mk(ad, 2'h1, 2'h2, 16'($urandom)), 10);
        frame(mk(ad, 2'h1, 2'h2, 16'($urandom)), 24);
        $display("abort test done");
        enable_n <= 1'b1;
        host.send(mk(ad, 2'h1, 2'h3, 16'($urandom)), 24);
        enable_n <= 1'b0;
        frame(mk(~ad, 2'h1, 2'h0, 16'($urandom)), 24);
        $display("enable test done");
        cmp(65'h0, 65'(q.size()), "pending");
        stop_test;
    end
endmodule
`default_nettype wire
